// >>> src/npic_pkg.sv
// Package of constants and types for the nested priority interrupt controller
package npic_pkg;
   // ----------------------------------------------------------------
   // Register map (byte offsets on the bus)
   // ----------------------------------------------------------------
   localparam logic [3:0] SENSE_OFS   = 4'h0;
   localparam logic [3:0] PRIO0_OFS   = 4'h4;
   localparam logic [3:0] PRIO1_OFS   = 4'h8;
   localparam logic [3:0] PRIO2_OFS   = 4'hc;
   localparam logic [5:0] PRIO3_OFS   = 6'h10;
   localparam logic [5:0] LEVEL_OFS   = 6'h14;
   localparam logic [5:0] PEND_OFS    = 6'h18;
   localparam logic [5:0] PEND_HI_OFS = 6'h1c;
   // ----------------------------------------------------------------
   // Reset values and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] PRIO_RST    = 8'hff;
   localparam logic [7:0] SENSE_RST   = 8'h00;
   localparam logic [7:0] PRIO3_RO    = 8'hf0;
   localparam logic [7:0] SENSE_MASK  = 8'h3f;
   localparam int         NUM_SRC     = 13;
   localparam int         NUM_EXT     = 3;
   localparam int         EXT_BASE    = 2;
   localparam int         SRC_WAKE    = 0;
   localparam int         SRC_OVF1    = 7;
   localparam int         SRC_RTC     = 10;
   // Level codes high:low
   localparam logic [1:0] LVL0        = 2'h2;
   localparam logic [1:0] LVL1        = 2'h1;
   localparam logic [1:0] LVL2        = 2'h0;
   localparam logic [1:0] LVL3        = 2'h3;
   // Sense codes
   localparam logic [1:0] SNS_FALL_LOW = 2'h0;
   localparam logic [1:0] SNS_RISE     = 2'h1;
   localparam logic [1:0] SNS_FALL     = 2'h2;
   localparam logic [1:0] SNS_BOTH     = 2'h3;
   // Vectors
   localparam logic [15:0] VEC_RESET  = 16'hfffe;
   localparam logic [15:0] VEC_TRAP   = 16'hfffc;
   localparam logic [15:0] VEC_SRC0   = 16'hfffa;
   // Halt modes
   typedef enum logic [1:0] {
      NPIC_RUN       = 2'h0,
      NPIC_HALT      = 2'h1,
      NPIC_ACT_HALT  = 2'h2,
      NPIC_WAKE_HALT = 2'h3
   } npic_halt_t;
   // Core level operations
   typedef enum logic [2:0] {
      NPIC_OP_NONE  = 3'h0,
      NPIC_OP_EI    = 3'h1,
      NPIC_OP_DI    = 3'h2,
      NPIC_OP_HALT  = 3'h3,
      NPIC_OP_WAIT  = 3'h4,
      NPIC_OP_POPCC = 3'h5,
      NPIC_OP_RET   = 3'h6,
      NPIC_OP_TRAP  = 3'h7
   } npic_op_t;
endpackage : npic_pkg

// >>> src/npic_ctrl.sv
// Nested priority interrupt controller with Wishbone register slave
//
// Functional notes
// - Priority registers reset FFh; upper bits reg3 read ones
// - Vector x pair in register x/4, bits 2*(x%4)
// - Pair encoding equals current-level encoding
// - Codes 10=L0, 01=L1, 00=L2, 11=L3
// - Reset and trap force level 3
// - Writing level-0 pattern keeps the old pair
// - Source 0 pair stored, ignored by arbitration
// - Raised priority re-enters still-pending running vector
// - Enable, halt, wait load level 0
// - Disable and trap load level 3
// - Pop and return reload level from memory
// - Branch flags for level 3 and not 3
// - Level instructions change running level until return
// - Fixed vectors, source 0 highest hardware priority
// - Only listed sources wake from halt modes
// - Sources 7 and 10 wake only active-halt
// - Sense fields 5:4, 3:2, 1:0 per line
// - Sense writes take effect only when masked
// - Sense change clears that line's pending latch
// - Sense codes: fall+low, rise, fall, both
// - Highest software level wins, ties by hardware
// - Serve only enabled and above current level
// - Edge latch clears on service entry
`timescale 1ns/10ps
`default_nettype none
module npic_ctrl #(
   parameter int NUM_SRC = npic_pkg::NUM_SRC
) (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // Wishbone classic slave
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [5:0]           wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic      [31:0]          wb_dat_o,
   output logic                      wb_ack_o,
   output logic                      wb_err_o,
   // Sources
   input  wire logic [NUM_SRC-1:0]   periph_req_i,
   input  wire logic [NUM_SRC-1:0]   src_enable_i,
   input  wire logic [2:0]           ext_line_i,
   // Core
   input  wire logic [2:0]           core_op_i,
   input  wire logic [1:0]           core_pop_level_i,
   input  wire logic                 core_ack_i,
   input  wire logic [1:0]           halt_mode_i,
   output logic                      irq_req_o,
   output logic      [3:0]           irq_src_o,
   output logic      [15:0]          irq_vec_o,
   output logic      [1:0]           cur_level_o,
   output logic                      branch_if_masked_o,
   output logic                      branch_if_unmasked_o,
   output logic                      wake_o
);
   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   logic        req_s;
   logic        wr_s;
   logic        hit_s;
   assign req_s = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
   assign hit_s = (wb_adr_i[1:0] == 2'h0) && (wb_adr_i <= npic_pkg::PEND_HI_OFS);
   assign wr_s  = req_s & hit_s & wb_we_i & wb_sel_i[0];

   logic [7:0]  prio_q [4];
   logic [7:0]  sense_q;
   logic [1:0]  cur_level_q;
   logic [NUM_SRC-1:0] ext_pend_q;
   logic [3:0]  run_src_q;
   logic        run_act_q;
   logic [2:0]  ext_s1_q;
   logic [2:0]  ext_s2_q;
   logic [2:0]  ext_s3_q;
   logic [2:0]  ext_lvl_q;

   // ----------------------------------------------------------------
   // Priority registers
   // ----------------------------------------------------------------
   genvar gr;
   generate
      for (gr = 0; gr < 4; gr++)
      begin : g_prio
         logic sel_s;
         assign sel_s = wr_s && (wb_adr_i[5:2] == 4'(gr + 1));
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
               prio_q[gr] <= npic_pkg::PRIO_RST;
            else if (sel_s)
            begin
               for (int p = 0; p < 4; p++)
               begin
                  // Level-0 pattern cannot be stored
                  if (wb_dat_i[2*p +: 2] != npic_pkg::LVL0)
                     prio_q[gr][2*p +: 2] <= wb_dat_i[2*p +: 2];
               end
               if (gr == 3)
                  prio_q[gr][7:4] <= 4'hf;
            end
         end
      end
   endgenerate

   // Per-source level; pair x in reg x/4 at 2*(x%4)
   logic [1:0] src_lvl_s [NUM_SRC];
   always_comb
   begin
      for (int x = 0; x < NUM_SRC; x++)
         src_lvl_s[x] = prio_q[x / 4][2 * (x % 4) +: 2];
      src_lvl_s[npic_pkg::SRC_WAKE] = npic_pkg::LVL1;
   end

   // Rank: L0=0, L1=1, L2=2, L3=3
   function automatic logic [1:0] npic_rank(input logic [1:0] c);
      unique case (c)
         npic_pkg::LVL0: npic_rank = 2'h0;
         npic_pkg::LVL1: npic_rank = 2'h1;
         npic_pkg::LVL2: npic_rank = 2'h2;
         npic_pkg::LVL3: npic_rank = 2'h3;
      endcase
   endfunction : npic_rank

   // ----------------------------------------------------------------
   // Sense register
   // ----------------------------------------------------------------
   logic sense_wr_s;
   logic masked_s;
   assign masked_s   = (cur_level_q == npic_pkg::LVL3);
   assign sense_wr_s = wr_s && (wb_adr_i == 6'(npic_pkg::SENSE_OFS)) && masked_s;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         sense_q <= npic_pkg::SENSE_RST;
      else if (sense_wr_s)
         sense_q <= wb_dat_i[7:0] & npic_pkg::SENSE_MASK;
   end

   // ----------------------------------------------------------------
   // External lines: three-stage synchroniser and latch
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ext_s1_q  <= 3'h7;
         ext_s2_q  <= 3'h7;
         ext_s3_q  <= 3'h7;
         ext_lvl_q <= 3'h7;
      end
      else
      begin
         ext_s1_q <= ext_line_i;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
         // Filtered level moves only once stages two and three agree
         for (int e = 0; e < 3; e++)
            if (ext_s2_q[e] == ext_s3_q[e])
               ext_lvl_q[e] <= ext_s3_q[e];
      end
   end

   logic [2:0] ext_new_s;
   logic [2:0] ext_rise_s;
   logic [2:0] ext_fall_s;
   logic [2:0] ext_edge_s;
   logic [2:0] ext_low_s;
   logic [2:0] ext_chg_s;
   always_comb
   begin
      for (int e = 0; e < 3; e++)
      begin
         ext_new_s[e]  = (ext_s2_q[e] == ext_s3_q[e]) ? ext_s3_q[e] : ext_lvl_q[e];
         ext_rise_s[e] = ext_new_s[e] & ~ext_lvl_q[e];
         ext_fall_s[e] = ~ext_new_s[e] & ext_lvl_q[e];
         unique case (sense_q[2*e +: 2])
            npic_pkg::SNS_FALL_LOW: ext_edge_s[e] = ext_fall_s[e];
            npic_pkg::SNS_RISE:     ext_edge_s[e] = ext_rise_s[e];
            npic_pkg::SNS_FALL:     ext_edge_s[e] = ext_fall_s[e];
            default:                ext_edge_s[e] = ext_rise_s[e] | ext_fall_s[e];
         endcase
         ext_low_s[e] = (sense_q[2*e +: 2] == npic_pkg::SNS_FALL_LOW) & ~ext_lvl_q[e];
         ext_chg_s[e] = sense_wr_s &&
                        ((wb_dat_i[2*e +: 2]) != sense_q[2*e +: 2]);
      end
   end

   // ----------------------------------------------------------------
   // Pending requests and arbitration
   // ----------------------------------------------------------------
   logic [NUM_SRC-1:0] pend_s;
   always_comb
   begin
      pend_s = periph_req_i;
      for (int e = 0; e < 3; e++)
         pend_s[npic_pkg::EXT_BASE + e] = ext_pend_q[npic_pkg::EXT_BASE + e] | ext_low_s[e];
   end

   // Halt wake capability per source
   logic [NUM_SRC-1:0] wake_cap_s;
   always_comb
   begin
      wake_cap_s = '0;
      unique case (npic_pkg::npic_halt_t'(halt_mode_i))
         npic_pkg::NPIC_RUN:      wake_cap_s = '1;
         npic_pkg::NPIC_HALT:     wake_cap_s[npic_pkg::EXT_BASE +: 3] = 3'h7;
         npic_pkg::NPIC_WAKE_HALT:
         begin
            wake_cap_s[npic_pkg::EXT_BASE +: 3] = 3'h7;
            wake_cap_s[npic_pkg::SRC_WAKE]      = 1'b1;
         end
         npic_pkg::NPIC_ACT_HALT:
         begin
            wake_cap_s[npic_pkg::EXT_BASE +: 3] = 3'h7;
            wake_cap_s[npic_pkg::SRC_OVF1]      = 1'b1;
            wake_cap_s[npic_pkg::SRC_RTC]       = 1'b1;
         end
      endcase
   end

   logic       win_s;
   logic [3:0] win_src_s;
   logic [1:0] win_rank_s;
   always_comb
   begin
      win_s      = 1'b0;
      win_src_s  = 4'h0;
      win_rank_s = 2'h0;
      // Scan from lowest hardware priority so the lower index wins ties
      for (int x = NUM_SRC - 1; x >= 0; x--)
      begin
         if (pend_s[x] && src_enable_i[x] && wake_cap_s[x] &&
             npic_rank(src_lvl_s[x]) > npic_rank(cur_level_q) &&
             (!win_s || npic_rank(src_lvl_s[x]) >= win_rank_s))
         begin
            win_s      = 1'b1;
            win_src_s  = 4'(x);
            win_rank_s = npic_rank(src_lvl_s[x]);
         end
      end
   end

   logic take_s;
   assign take_s = core_ack_i & irq_req_o;

   // Edge latches; set wins over clear on same cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ext_pend_q <= '0;
      else
         for (int e = 0; e < 3; e++)
         begin
            if (ext_edge_s[e])
               ext_pend_q[npic_pkg::EXT_BASE + e] <= 1'b1;
            else if (ext_chg_s[e])
               ext_pend_q[npic_pkg::EXT_BASE + e] <= 1'b0;
            else if (take_s && irq_src_o == 4'(npic_pkg::EXT_BASE + e))
               ext_pend_q[npic_pkg::EXT_BASE + e] <= 1'b0;
         end
   end

   // ----------------------------------------------------------------
   // Current level
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         cur_level_q <= npic_pkg::LVL3;
      else if (take_s)
         cur_level_q <= src_lvl_s[irq_src_o];
      else
         unique case (npic_pkg::npic_op_t'(core_op_i))
            npic_pkg::NPIC_OP_EI,
            npic_pkg::NPIC_OP_HALT,
            npic_pkg::NPIC_OP_WAIT:  cur_level_q <= npic_pkg::LVL0;
            npic_pkg::NPIC_OP_DI,
            npic_pkg::NPIC_OP_TRAP:  cur_level_q <= npic_pkg::LVL3;
            npic_pkg::NPIC_OP_POPCC,
            npic_pkg::NPIC_OP_RET:   cur_level_q <= core_pop_level_i;
            npic_pkg::NPIC_OP_NONE:  cur_level_q <= cur_level_q;
         endcase
   end

   // Running vector tracks nesting only one deep; run_act_q is read back in the level register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         run_act_q <= 1'b0;
         run_src_q <= 4'h0;
      end
      else if (take_s)
      begin
         run_act_q <= 1'b1;
         run_src_q <= irq_src_o;
      end
      else if (npic_pkg::npic_op_t'(core_op_i) == npic_pkg::NPIC_OP_RET)
         run_act_q <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Core outputs
   // ----------------------------------------------------------------
   // Re-entry of a running vector after a priority raise falls out of
   // the same comparison against the current level
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_req_o <= 1'b0;
         irq_src_o <= 4'h0;
         irq_vec_o <= npic_pkg::VEC_RESET;
      end
      else
      begin
         irq_req_o <= win_s & ~take_s;
         irq_src_o <= win_src_s;
         irq_vec_o <= npic_pkg::VEC_SRC0 - {11'h0, win_src_s, 1'b0};
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cur_level_o          <= npic_pkg::LVL3;
         branch_if_masked_o   <= 1'b1;
         branch_if_unmasked_o <= 1'b0;
         wake_o               <= 1'b0;
      end
      else
      begin
         cur_level_o          <= cur_level_q;
         branch_if_masked_o   <= masked_s;
         branch_if_unmasked_o <= ~masked_s;
         wake_o               <= |(pend_s & src_enable_i & wake_cap_s) &&
                                 (npic_pkg::npic_halt_t'(halt_mode_i) != npic_pkg::NPIC_RUN);
      end
   end

   // ----------------------------------------------------------------
   // Bus answer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end
      else
      begin
         wb_ack_o <= req_s & hit_s;
         wb_err_o <= req_s & ~hit_s;
         wb_dat_o <= 32'h0;
         if (req_s && hit_s && !wb_we_i)
            unique case (wb_adr_i)
               6'(npic_pkg::SENSE_OFS): wb_dat_o <= {24'h0, sense_q};
               6'(npic_pkg::PRIO0_OFS): wb_dat_o <= {24'h0, prio_q[0]};
               6'(npic_pkg::PRIO1_OFS): wb_dat_o <= {24'h0, prio_q[1]};
               6'(npic_pkg::PRIO2_OFS): wb_dat_o <= {24'h0, prio_q[2]};
               npic_pkg::PRIO3_OFS:     wb_dat_o <= {24'h0, prio_q[3] | npic_pkg::PRIO3_RO};
               npic_pkg::LEVEL_OFS:     wb_dat_o <= {28'h0, run_act_q, 1'b0, cur_level_q};
               npic_pkg::PEND_OFS:      wb_dat_o <= {24'h0, pend_s[7:0]};
               default:                 wb_dat_o <= {27'h0, pend_s[NUM_SRC-1:8]};
            endcase
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_write_level0;
      wr_s && wb_adr_i == 6'(npic_pkg::PRIO0_OFS) && wb_dat_i[1:0] == npic_pkg::LVL0;
   endsequence
   keep_pair_a: assert property (@(posedge clk_i) disable iff (rst_i)
      s_write_level0 |=> prio_q[0][1:0] == $past(prio_q[0][1:0]))
      else $error("level-0 write changed a pair");
   prio3_ro_a: assert property (@(posedge clk_i) disable iff (rst_i)
      prio_q[3][7:4] == 4'hf)
      else $error("read-only bits lost");
   sense_lock_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_s && wb_adr_i == 6'h0 && !masked_s |=> $stable(sense_q))
      else $error("sense written while unmasked");
   ei_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !take_s && core_op_i == 3'(npic_pkg::NPIC_OP_EI) |=> cur_level_q == npic_pkg::LVL0)
      else $error("enable did not load level 0");
   di_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !take_s && core_op_i == 3'(npic_pkg::NPIC_OP_DI) |=> cur_level_q == npic_pkg::LVL3)
      else $error("disable did not load level 3");
   pop_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !take_s && core_op_i == 3'(npic_pkg::NPIC_OP_RET)
      |=> cur_level_q == $past(core_pop_level_i))
      else $error("return did not restore level");
   branch_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 branch_if_masked_o == ($past(cur_level_q) == npic_pkg::LVL3)
      && branch_if_masked_o != branch_if_unmasked_o)
      else $error("branch flags wrong");
   above_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
      win_s |-> npic_rank(src_lvl_s[win_src_s]) > npic_rank(cur_level_q))
      else $error("grant not above current level");
   edge_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      take_s && irq_src_o == 4'h3 && !ext_edge_s[1] |=> !ext_pend_q[3])
      else $error("edge latch not cleared on entry");
   sense_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ext_chg_s[1] && !ext_edge_s[1] |=> !ext_pend_q[3])
      else $error("sense change kept pending");
   halt_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
      halt_mode_i == 2'(npic_pkg::NPIC_HALT) && win_s |-> win_src_s inside {4'h2, 4'h3, 4'h4})
      else $error("non-wake source granted in halt");
endmodule : npic_ctrl
`default_nettype wire

// >>> verif/npic_core_model.sv
// Behavioural core that takes interrupt requests after a chosen delay
`timescale 1ns/10ps
`default_nettype none
module npic_core_model (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       irq_req_i,
   input  wire logic       en_i,
   input  wire logic [3:0] delay_i,
   output logic            core_ack_o
);
   logic [3:0] cnt_q;

   // Acks only while the request stands, never two cycles in a row
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !en_i || !irq_req_i || core_ack_o)
      begin
         cnt_q      <= 4'h0;
         core_ack_o <= 1'b0;
      end
      else if (cnt_q == delay_i)
         core_ack_o <= 1'b1;
      else
         cnt_q <= cnt_q + 4'h1;
   end
endmodule : npic_core_model
`default_nettype wire

// >>> verif/npic_ctrl_bench.sv
// Self-checking bench for the nested priority interrupt controller
`timescale 1ns/10ps
`default_nettype none
module npic_ctrl_bench;
   logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, en = 0;
   logic        wb_ack_o, wb_err_o, irq_req_o, mk, um, wake_o, core_ack_i, e;
   logic [5:0]  wb_adr_i = 0;
   logic [3:0]  wb_sel_i = 0, dly = 0, irq_src_o;
   logic [31:0] wb_dat_i = 0, wb_dat_o, q;
   logic [12:0] preq = 0, sen = 0;
   logic [2:0]  ext = 3'h7, op = 0;
   logic [1:0]  popl = 0, hm = 0, cur_level_o;
   logic [15:0] irq_vec_o;
   logic [7:0]  pr [4], d;
   int          bad_count = 0, n_checks = 0, w, r;
   logic [2:0]  ops [6] = '{3'h4, 3'h3, 3'h2, 3'h5, 3'h7, 3'h6};
   logic [1:0]  lv [6] = '{2'h2, 2'h2, 2'h3, 2'h1, 2'h3, 2'h0};
   localparam logic [5:0] SNS = {2'h0, npic_pkg::SENSE_OFS};

   npic_ctrl i_npic_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
      .periph_req_i(preq), .src_enable_i(sen), .ext_line_i(ext), .core_op_i(op),
      .core_pop_level_i(popl), .core_ack_i(core_ack_i), .halt_mode_i(hm),
      .irq_req_o(irq_req_o), .irq_src_o(irq_src_o), .irq_vec_o(irq_vec_o),
      .cur_level_o(cur_level_o), .branch_if_masked_o(mk), .branch_if_unmasked_o(um),
      .wake_o(wake_o));
   npic_core_model i_npic_core_model (.clk_i(clk_i), .rst_i(rst_i), .irq_req_i(irq_req_o),
      .en_i(en), .delay_i(dly), .core_ack_o(core_ack_i));

   // ----------------------------------------------------------------
   // Expectations and checks
   // ----------------------------------------------------------------
   function automatic logic [1:0] pair(int s);
      logic [7:0] v;
      v = pr[s / 4] >> (2 * (s % 4));
      return v[1:0];
   endfunction : pair

   function automatic int rank(int s);
      logic [1:0] p;
      p = pair(s);
      if (s == 0)
         return 1;
      return (p == 2'h2) ? 0 : (p == 2'h1) ? 1 : (p == 2'h0) ? 2 : 3;
   endfunction : rank

   // Level-0 pattern never lands in a pair
   function automatic logic [7:0] merge(logic [7:0] o, logic [7:0] n, int reg_no);
      logic [7:0] v;
      v = n;
      for (int i = 0; i < 4; i++)
         if (n[2*i+:2] == npic_pkg::LVL0)
            v[2*i+:2] = o[2*i+:2];
      if (reg_no == 3)
         v[7:4] = 4'hf;
      return v;
   endfunction : merge

   function automatic int winner();
      int b, br;
      b  = -1;
      br = -1;
      for (int s = 0; s < npic_pkg::NUM_SRC; s++)
         if (preq[s] && rank(s) > br)
         begin
            b  = s;
            br = rank(s);
         end
      return b;
   endfunction : winner

   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      n_checks++;
      if (g !== x)
      begin
         bad_count++;
         $display("ERROR %0t: value %h expected %h", $time, g, x);
      end
   endtask : chk

   task automatic chk_flag(input logic g, input logic x);
      n_checks++;
      if (g !== x)
      begin
         bad_count++;
         $display("ERROR %0t: flag %b expected %b", $time, g, x);
      end
   endtask : chk_flag

   // Bounded wait: 0 for the request, 1 for the core's ack
   task automatic await(input int which);
      int n;
      n = 0;
      while ((which ? core_ack_i : irq_req_o) !== 1'b1 && n < 20)
      begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 20)
      begin
         bad_count++;
         $display("ERROR %0t: wait expired", $time);
         conclude();
      end
   endtask : await

   task automatic wb(input logic we, input logic [5:0] a, input logic [7:0] dd);
      int n;
      n = 0;
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} <= {2'h3, we, a};
      wb_sel_i <= 4'h1;
      wb_dat_i <= {24'h0, dd};
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (!(wb_ack_o === 1'b1 || wb_err_o === 1'b1) && n < 20);
      q = wb_dat_o;
      e = wb_err_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
      if (n >= 20)
      begin
         bad_count++;
         $display("ERROR %0t: bus timeout", $time);
         conclude();
      end
   endtask : wb

   task automatic rdc(input logic [5:0] a, input logic [7:0] x);
      wb(1'b0, a, 8'h00);
      chk(q, {24'h0, x});
   endtask : rdc

   task automatic core(input logic [2:0] c, input logic [1:0] pl);
      @(posedge clk_i);
      op   <= c;
      popl <= pl;
      @(posedge clk_i);
      op <= 3'h0;
      repeat (2) @(posedge clk_i);
   endtask : core

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial forever #5 clk_i = ~clk_i;
   initial
   begin
      repeat (100000) @(posedge clk_i);
      bad_count++;
      conclude();
   end

   initial
   begin
      void'($urandom(32'h33fce137));
      pr = '{default: npic_pkg::PRIO_RST};
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      chk(cur_level_o, npic_pkg::LVL3);
      chk_flag(mk, 1'b1);
      rdc(SNS, npic_pkg::SENSE_RST);
      for (int i = 0; i < 4; i++)
         rdc(6'(4 * i + 4), 8'hff);
      wb(1'b0, 6'h20, 8'h00);
      chk_flag(e, 1'b1);
      $display("test reset done");
      wb(1'b1, 6'h04, 8'hcf);
      wb(1'b1, 6'h04, 8'h64);
      rdc(6'h04, 8'h44);
      pr[0] = 8'h44;
      repeat (12)
      begin
         r = $urandom_range(3);
         d = 8'($urandom);
         wb(1'b1, 6'(4 * r + 4), d);
         pr[r] = merge(pr[r], d, r);
         rdc(6'(4 * r + 4), pr[r]);
      end
      $display("test priority registers done");
      for (int c = 0; c < 4; c++)
      begin
         wb(1'b1, SNS, {2'h0, 2'(c), 2'(c), 2'(c)});
         rdc(SNS, {2'h0, 2'(c), 2'(c), 2'(c)});
      end
      wb(1'b1, SNS, 8'h2a);
      core(3'h1, 2'h0);
      chk(cur_level_o, npic_pkg::LVL0);
      chk_flag(um, 1'b1);
      wb(1'b1, SNS, 8'h15);
      rdc(SNS, 8'h2a);
      for (int i = 0; i < 6; i++)
      begin
         core(ops[i], lv[i]);
         chk(cur_level_o, lv[i]);
         chk_flag(mk, lv[i] == 2'h3);
      end
      $display("test level operations done");
      for (int i = 0; i < 4; i++)
      begin
         d = 8'($urandom) & 8'h55;
         wb(1'b1, 6'(4 * i + 4), d);
         pr[i] = merge(pr[i], d, i);
      end
      sen  <= 13'h1fff;
      core(3'h2, 2'h0);
      preq <= 13'h0001;
      repeat (3) @(posedge clk_i);
      chk_flag(irq_req_o, 1'b0);
      preq <= 13'h0;
      core(3'h1, 2'h0);
      repeat (10)
      begin
         preq <= (13'($urandom) & 13'h1fe3) | 13'h1000;
         @(posedge clk_i);
         await(0);
         w = winner();
         chk(irq_src_o, 32'(w));
         chk(irq_vec_o, npic_pkg::VEC_SRC0 - 16'(2 * w));
         en  <= 1'b1;
         dly <= 4'($urandom_range(3));
         await(1);
         en <= 1'b0;
         repeat (2) @(posedge clk_i);
         if (w != 0)
            chk(cur_level_o, pair(w));
         preq <= 13'h0;
         core(3'h6, npic_pkg::LVL0);
      end
      $display("test arbitration done");
      hm   <= 2'h1;
      preq <= 13'h0002;
      repeat (4) @(posedge clk_i);
      chk_flag(irq_req_o, 1'b0);
      chk_flag(wake_o, 1'b0);
      ext <= 3'h5;
      await(0);
      chk(irq_src_o, 32'd3);
      chk_flag(wake_o, 1'b1);
      en <= 1'b1;
      await(1);
      en <= 1'b0;
      core(3'h6, npic_pkg::LVL0);
      repeat (8) @(posedge clk_i);
      chk_flag(irq_req_o, 1'b0);
      ext <= 3'h7;
      $display("test external line done");
      conclude();
   end
endmodule : npic_ctrl_bench
`default_nettype wire
